// ==== core/wdt_pkg.sv ====
// Purpose: Constants for the watchdog timer with early warning
// Assumes: Byte-wide special function register port, one 40 MHz clock
// Notes:   Counts are in oscillator clocks; the divider is not used here
package wdt_pkg;

    // Register offsets on the special function register port
    localparam logic [7:0] WDT_ADDR_CLK_PERIOD = 8'h8e;
    localparam logic [7:0] WDT_ADDR_WD_CTRL    = 8'hd8;
    localparam logic [7:0] WDT_ADDR_EXT_IE     = 8'he8;
    localparam logic [7:0] WDT_ADDR_EXT_IP     = 8'hf8;
    localparam logic [7:0] WDT_ADDR_KEY        = 8'hc7;

    // Field positions
    localparam int WDT_POS_SEL_HI   = 7;
    localparam int WDT_POS_SEL_LO   = 6;
    localparam int WDT_POS_IRQ_FLAG = 3;
    localparam int WDT_POS_RST_FLAG = 2;
    localparam int WDT_POS_RST_EN   = 1;
    localparam int WDT_POS_RESTART  = 0;
    localparam int WDT_POS_IRQ_EN   = 6;
    localparam int WDT_POS_IRQ_PRI  = 6;

    // Reset values
    localparam logic [7:0] WDT_RST_CLK_PERIOD = 8'h01;
    localparam logic [7:0] WDT_RST_EXT_IE     = 8'h00;
    localparam logic [7:0] WDT_RST_EXT_IP     = 8'h00;

    // Timed access key bytes and window timer load; the window stays open one clock longer
    localparam logic [7:0] WDT_KEY1       = 8'haa;
    localparam logic [7:0] WDT_KEY2       = 8'h55;
    localparam int         WDT_KEY_WINDOW = 3;

    // Time-out exponents and the warning lead
    localparam int WDT_EXP_SEL0 = 17;
    localparam int WDT_EXP_SEL1 = 20;
    localparam int WDT_EXP_SEL2 = 23;
    localparam int WDT_EXP_SEL3 = 26;
    localparam int WDT_WARN_LEAD = 512;
    localparam int WDT_CNT_W     = 27;

    // Timed access sequencer
    typedef enum logic [1:0]
    {
        WDT_KEY_IDLE = 2'b00,
        WDT_KEY_HALF = 2'b01,
        WDT_KEY_OPEN = 2'b10
    } wdt_key_state_t;

endpackage

// ==== core/wdt_core.sv ====
// Purpose: Watchdog timer with an interrupt 512 clocks ahead of reset
// Assumes: Register port with one-cycle strobes, read data the next cycle
// Notes:   Restart and reset enable only change inside a timed access window
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Counter flags at selected time-out, holds at reset point
// - Restart bit clears count to zero
// - Period select in bits 7:6
// - Interrupt at 2^17/20/23/26 clocks
// - Reset flag 512 clocks after interrupt
// - Enabled reset time-out sets flag, resets core
// - Restart and reset enable need timed access
// - Interrupt request only when enable set
// - Interrupt flag set regardless of reset enable
// - Interrupt usable as time base and wake-up
// - Counts plain oscillator clocks
module wdt_core
    import wdt_pkg::*;
#(
    parameter int CNT_W    = WDT_CNT_W,
    parameter int EXP_SEL0 = WDT_EXP_SEL0,
    parameter int EXP_SEL1 = WDT_EXP_SEL1,
    parameter int EXP_SEL2 = WDT_EXP_SEL2,
    parameter int EXP_SEL3 = WDT_EXP_SEL3
)
(
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    // Register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // Core side
    output logic            irq_o,
    output logic            irq_priority_o,
    output logic            wake_o,
    output logic            core_reset_o
);

    logic [7:0]         clk_period_q;
    logic [7:0]         ext_ie_q;
    logic [7:0]         ext_ip_q;
    logic               irq_flag_q;
    logic               rst_flag_q;
    logic               rst_en_q;
    logic [CNT_W-1:0]   count_q;
    logic               core_reset_q;
    logic [7:0]         rdata_q;
    logic               at_rst_q;
    wdt_key_state_t     key_state_q;
    logic [1:0]         key_timer_q;

    logic               wr_period;
    logic               wr_ctrl;
    logic               wr_ie;
    logic               wr_ip;
    logic               wr_key;
    logic               key_open;
    logic               restart;
    logic [CNT_W-1:0]   irq_point;
    logic [CNT_W-1:0]   rst_point;
    logic               hit_irq;
    logic               hit_rst;
    logic               arrive_rst;

    assign wr_period = reg_wr_i && (reg_addr_i == WDT_ADDR_CLK_PERIOD);
    assign wr_ctrl   = reg_wr_i && (reg_addr_i == WDT_ADDR_WD_CTRL);
    assign wr_ie     = reg_wr_i && (reg_addr_i == WDT_ADDR_EXT_IE);
    assign wr_ip     = reg_wr_i && (reg_addr_i == WDT_ADDR_EXT_IP);
    assign wr_key    = reg_wr_i && (reg_addr_i == WDT_ADDR_KEY);
    assign key_open  = (key_state_q == WDT_KEY_OPEN);

    // Restart only counts when the key sequence has opened the window
    assign restart = wr_ctrl && key_open && reg_wdata_i[WDT_POS_RESTART];

    // Interrupt point from the two select bits
    always_comb
    begin
        unique case (clk_period_q[WDT_POS_SEL_HI:WDT_POS_SEL_LO])
            2'b00: irq_point = CNT_W'(1) << EXP_SEL0;
            2'b01: irq_point = CNT_W'(1) << EXP_SEL1;
            2'b10: irq_point = CNT_W'(1) << EXP_SEL2;
            2'b11: irq_point = CNT_W'(1) << EXP_SEL3;
        endcase
    end

    assign rst_point = irq_point + CNT_W'(WDT_WARN_LEAD);
    assign hit_irq   = (count_q == irq_point);
    assign hit_rst   = (count_q == rst_point);

    // Count holds on the reset point, so only its arrival may fire reset once
    assign arrive_rst = hit_rst && !at_rst_q;

    // Timed access: key1 then key2 opens a short write window
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            key_state_q <= WDT_KEY_IDLE;
            key_timer_q <= 2'd0;
        end
        else if (wr_key && reg_wdata_i == WDT_KEY1)
        begin
            key_state_q <= WDT_KEY_HALF;
            key_timer_q <= 2'(WDT_KEY_WINDOW);
        end
        else if (wr_key && reg_wdata_i == WDT_KEY2 && key_state_q == WDT_KEY_HALF)
        begin
            key_state_q <= WDT_KEY_OPEN;
            key_timer_q <= 2'(WDT_KEY_WINDOW);
        end
        else if (key_state_q != WDT_KEY_IDLE)
        begin
            // Window closes after a control write, any other key write, or when it times out
            if (wr_ctrl || key_timer_q == 2'd0 || wr_key)
                key_state_q <= WDT_KEY_IDLE;
            key_timer_q <= (key_timer_q == 2'd0) ? 2'd0 : key_timer_q - 2'd1;
        end
    end

    // Counter runs on every oscillator clock, no prescaler
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            count_q <= '0;
        else if (restart)
            count_q <= '0;
        else if (!hit_rst)
            count_q <= count_q + CNT_W'(1);
    end

    // Plain configuration registers
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            clk_period_q <= WDT_RST_CLK_PERIOD;
            ext_ie_q     <= WDT_RST_EXT_IE;
            ext_ip_q     <= WDT_RST_EXT_IP;
        end
        else
        begin
            if (wr_period)
                clk_period_q <= reg_wdata_i;
            if (wr_ie)
                ext_ie_q <= reg_wdata_i;
            if (wr_ip)
                ext_ip_q <= reg_wdata_i;
        end
    end

    // Reset enable is protected; unkeyed writes leave it alone
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_en_q <= 1'b0;
        else if (wr_ctrl && key_open)
            rst_en_q <= reg_wdata_i[WDT_POS_RST_EN];
    end

    // Sticky flags: hardware set wins over a software clear
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            irq_flag_q <= 1'b0;
            rst_flag_q <= 1'b0;
        end
        else
        begin
            if (hit_irq && !restart)
                irq_flag_q <= 1'b1;
            else if (wr_ctrl && reg_wdata_i[WDT_POS_IRQ_FLAG])
                irq_flag_q <= 1'b0;
            if (arrive_rst && rst_en_q && !restart)
                rst_flag_q <= 1'b1;
            else if (wr_ctrl && reg_wdata_i[WDT_POS_RST_FLAG])
                rst_flag_q <= 1'b0;
        end
    end

    // Remembers that the held count already sits on the reset point
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            at_rst_q <= 1'b0;
        else
            at_rst_q <= hit_rst && !restart;
    end

    // Core reset pulse, one cycle when the reset point is reached
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            core_reset_q <= 1'b0;
        else
            core_reset_q <= arrive_rst && rst_en_q && !restart;
    end

    // Read data the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_q <= 8'h00;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                WDT_ADDR_CLK_PERIOD: rdata_q <= clk_period_q;
                WDT_ADDR_WD_CTRL:    rdata_q <= {4'h0, irq_flag_q, rst_flag_q, rst_en_q, 1'b0};
                WDT_ADDR_EXT_IE:     rdata_q <= ext_ie_q;
                WDT_ADDR_EXT_IP:     rdata_q <= ext_ip_q;
                default:             rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end

    assign reg_rdata_o    = rdata_q;
    assign irq_o          = irq_flag_q && ext_ie_q[WDT_POS_IRQ_EN];
    assign irq_priority_o = ext_ip_q[WDT_POS_IRQ_PRI];
    assign wake_o         = irq_o;
    assign core_reset_o   = core_reset_q;

    // Unkeyed control writes never change the reset enable
    property p_key_guard;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (wr_ctrl && !key_open) |=> (rst_en_q == $past(rst_en_q));
    endproperty
    a_key_guard: assert property (p_key_guard) else $error("unkeyed write changed enable");

    // Restart zeroes the counter
    property p_restart;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        restart |=> (count_q == '0);
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear count");

    // Reaching the interrupt point raises the flag
    property p_irq_set;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (hit_irq && !restart) |=> irq_flag_q;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt flag missed");

    // Reset point lies 512 counts after the interrupt point
    property p_lead;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        hit_rst |-> (count_q - irq_point == CNT_W'(512));
    endproperty
    a_lead: assert property (p_lead) else $error("warning lead wrong");

    // Enabled reset point pulses core reset next cycle
    property p_core_rst;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (arrive_rst && rst_en_q && !restart) |=> (core_reset_o && rst_flag_q);
    endproperty
    a_core_rst: assert property (p_core_rst) else $error("core reset missing");

    // Interrupt output needs the enable bit
    property p_irq_gate;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        irq_o |-> (ext_ie_q[6] && irq_flag_q);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("ungated interrupt");

    // Counter advances by one each clock between events
    property p_count;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!restart && !hit_rst) |=> (count_q == $past(count_q) + CNT_W'(1));
    endproperty
    a_count: assert property (p_count) else $error("count did not advance");

    // Code 00 gives the shortest interrupt point
    property p_sel0;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (clk_period_q[7:6] == 2'b00) |-> (irq_point == CNT_W'(2 ** EXP_SEL0));
    endproperty
    a_sel0: assert property (p_sel0) else $error("period code 00 wrong");

    // Core reset is a single-cycle pulse, even while the count holds
    property p_core_pulse;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        core_reset_o |=> !core_reset_o;
    endproperty
    a_core_pulse: assert property (p_core_pulse) else $error("core reset too long");

    // Interrupt flag stays set until software writes a one to it
    property p_irq_hold;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (irq_flag_q && !(wr_ctrl && reg_wdata_i[WDT_POS_IRQ_FLAG])) |=> irq_flag_q;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq flag dropped");

    // A disabled reset point neither pulses reset nor sets the flag
    property p_rst_off;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (arrive_rst && !rst_en_q && !rst_flag_q) |=> (!core_reset_o && !rst_flag_q);
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("reset fired while disabled");

endmodule

`default_nettype wire

// ==== dv/wdt_tb.sv ====
// Purpose: Self-checking bench for the watchdog timer with early warning
// Assumes: Register port of wdt_core, 40 MHz clock, shortened time-out exponents
// Notes:   Exponents 10 to 13 stand in for the long points to keep the run short
`timescale 1ns/1ps
`default_nettype none
module testbench
    import wdt_pkg::*;
;
    // Short exponents; the 512-clock warning lead stays as it is
    localparam int E0 = 10;
    localparam int E1 = 11;
    localparam int E2 = 12;
    localparam int E3 = 13;
    localparam int P0 = 1 << E0;
    logic       clk_sys_i   = 1'b0;
    logic       reset_n_i   = 1'b0;
    logic [7:0] reg_addr_i  = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i    = 1'b0;
    logic       reg_rd_i    = 1'b0;
    logic [7:0] reg_rdata_o;
    logic       irq_o;
    logic       irq_priority_o;
    logic       wake_o;
    logic       core_reset_o;
    int         failures    = 0;
    int         comparisons = 0;
    int         cycles      = 0;

    // Clock at 25 ns
    always #12.5 clk_sys_i = ~clk_sys_i;

    wdt_core #(.CNT_W(WDT_CNT_W), .EXP_SEL0(E0), .EXP_SEL1(E1), .EXP_SEL2(E2), .EXP_SEL3(E3))
        dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
        .irq_priority_o(irq_priority_o), .wake_o(wake_o), .core_reset_o(core_reset_o));

    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard, about twice the cycles the tests should take
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            final_report();
        end
    end

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // One-cycle write strobe, signals launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        // Let the write settle so callers see the updated outputs
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk8(nm, e, reg_rdata_o);
    endtask

    // Key pair then the protected control write
    task automatic keyed(input logic [7:0] d);
        wr(WDT_ADDR_KEY, WDT_KEY1);
        wr(WDT_ADDR_KEY, WDT_KEY2);
        wr(WDT_ADDR_WD_CTRL, d);
    endtask

    task automatic t_reset();
        chk1("irq_o", 1'b0, irq_o);
        chk1("core_reset_o", 1'b0, core_reset_o);
        chk1("irq_priority_o", 1'b0, irq_priority_o);
        chk1("wake_o", 1'b0, wake_o);
        rchk("period", WDT_ADDR_CLK_PERIOD, WDT_RST_CLK_PERIOD);
        @(posedge clk_sys_i);
        #1;
        chk8("rdata idle", 8'h00, reg_rdata_o);
        rchk("ctrl", WDT_ADDR_WD_CTRL, 8'h00);
        rchk("ie", WDT_ADDR_EXT_IE, WDT_RST_EXT_IE);
        rchk("ip", WDT_ADDR_EXT_IP, WDT_RST_EXT_IP);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(WDT_ADDR_CLK_PERIOD, 8'hc0);
        rchk("period", WDT_ADDR_CLK_PERIOD, 8'hc0);
        wr(WDT_ADDR_EXT_IP, 8'h40);
        chk1("irq_priority_o", 1'b1, irq_priority_o);
        wr(WDT_ADDR_EXT_IP, 8'h00);
        wr(8'h10, 8'h5a);
        rchk("unmapped", 8'h10, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_guard();
        wr(WDT_ADDR_WD_CTRL, 8'h03);
        rchk("ctrl open", WDT_ADDR_WD_CTRL, 8'h00);
        keyed(8'h02);
        rchk("ctrl keyed", WDT_ADDR_WD_CTRL, 8'h02);
        // Keys given, but the control write comes after the window closed
        wr(WDT_ADDR_KEY, WDT_KEY1);
        wr(WDT_ADDR_KEY, WDT_KEY2);
        repeat (6) @(posedge clk_sys_i);
        wr(WDT_ADDR_WD_CTRL, 8'h00);
        rchk("ctrl late", WDT_ADDR_WD_CTRL, 8'h02);
        $display("test guard done");
    endtask

    // Select, restart, enable, restart again mid-count, then time warning and reset
    task automatic t_timeout();
        int n;
        int m;
        n = 0;
        m = 0;
        wr(WDT_ADDR_CLK_PERIOD, 8'h00);
        wr(WDT_ADDR_WD_CTRL, 8'h0c);
        wr(WDT_ADDR_EXT_IE, 8'h40);
        keyed(8'h01);
        keyed(8'h03);
        repeat (500) @(posedge clk_sys_i);
        #1;
        chk1("no early irq", 1'b0, irq_o);
        keyed(8'h03);
        while (irq_o !== 1'b1 && n < P0 + 100)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        // Flag register adds one clock after the count reaches the point
        chk32("irq cycles", P0 + 1, n);
        chk1("wake_o", 1'b1, wake_o);
        while (core_reset_o !== 1'b1 && m < 600)
        begin
            @(posedge clk_sys_i);
            #1;
            m++;
        end
        chk32("reset lead", WDT_WARN_LEAD, m);
        chk1("irq beside reset", 1'b1, irq_o);
        @(posedge clk_sys_i);
        #1;
        chk1("core_reset pulse", 1'b0, core_reset_o);
        rchk("ctrl flags", WDT_ADDR_WD_CTRL, 8'h0e);
        wr(WDT_ADDR_EXT_IE, 8'h00);
        chk1("irq masked", 1'b0, irq_o);
        chk1("wake masked", 1'b0, wake_o);
        keyed(8'h01);
        rchk("flags sticky", WDT_ADDR_WD_CTRL, 8'h0c);
        wr(WDT_ADDR_WD_CTRL, 8'h0c);
        rchk("flags cleared", WDT_ADDR_WD_CTRL, 8'h00);
        $display("test timeout done");
    endtask

    // One period code: select, clear, restart, time the warning, pass the reset point
    task automatic run_period(input logic [7:0] sel, input int p);
        int   n;
        logic seen;
        n    = 0;
        seen = 1'b0;
        wr(WDT_ADDR_CLK_PERIOD, sel);
        wr(WDT_ADDR_WD_CTRL, 8'h0c);
        keyed(8'h01);
        while (irq_o !== 1'b1 && n < p + 100)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        chk32("irq cycles", p + 1, n);
        repeat (520)
        begin
            @(posedge clk_sys_i);
            #1;
            seen = seen | core_reset_o;
        end
        chk1("reset while disabled", 1'b0, seen);
        rchk("flag without enable", WDT_ADDR_WD_CTRL, 8'h08);
    endtask

    // The three longer codes, each timed from its own restart
    task automatic t_periods();
        wr(WDT_ADDR_EXT_IE, 8'h40);
        run_period(8'h40, 1 << E1);
        run_period(8'h80, 1 << E2);
        run_period(8'hc0, 1 << E3);
        $display("test periods done");
    endtask

    // Reset held 20 cycles, inputs already idle
    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_regs();
        t_guard();
        t_timeout();
        t_periods();
        final_report();
    end
endmodule
`default_nettype wire
